/* hdl/hpc_config_regs.v */
// i2c-reached configuration register bank for a dual-slot hot-plug controller
`include "hpc_consts.vh"

module hpc_config_regs #(
    parameter [6:0] DEV_ADDR = 7'h40
) (
    input wire ref_clk,
    input wire rst_n,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe,
    input wire a_lo_enable_pin,
    input wire a_hi_output_low,
    input wire a_lo_output_low,
    input wire b_hi_output_low,
    output wire a_pass_gate_out,
    output wire a_blocking_gate_out,
    output wire a_lo_gate_drive,
    output wire b_pass_gate_out,
    output wire b_blocking_gate_out,
    output wire [3:0] a_hi_current_limit_code,
    output wire [3:0] b_hi_current_limit_code,
    output wire [6:0] a_hi_limit_pct,
    output wire [6:0] b_hi_limit_pct,
    output wire [9:0] a_hi_limit_mv,
    output wire [9:0] b_hi_limit_mv,
    output wire [6:0] a_hi_fast_trip_mv,
    output wire [6:0] b_hi_fast_trip_mv,
    output wire [1:0] a_hi_power_good_code,
    output wire [1:0] b_hi_power_good_code,
    output wire [13:0] a_hi_power_good_mv,
    output wire [13:0] b_hi_power_good_mv,
    output wire a_hi_positive_turnoff_sel,
    output wire b_hi_positive_turnoff_sel,
    output wire signed [3:0] a_hi_turnoff_mv,
    output wire signed [3:0] b_hi_turnoff_mv,
    output wire [4:0] a_hi_fault_time_code,
    output wire [4:0] a_lo_fault_time_code,
    output wire [4:0] b_hi_fault_time_code,
    output wire [13:0] a_hi_fault_time_us,
    output wire [13:0] a_lo_fault_time_us,
    output wire [13:0] b_hi_fault_time_us,
    output wire a_hi_bleed_connect,
    output wire a_lo_bleed_connect,
    output wire b_hi_bleed_connect
);

    // ----------------------------------------------------------------
    // i2c states
    // ----------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_DEV = 3'd1;
    localparam [2:0] ST_ACKD = 3'd2;
    localparam [2:0] ST_WR = 3'd3;
    localparam [2:0] ST_ACKW = 3'd4;
    localparam [2:0] ST_RD = 3'd5;
    localparam [2:0] ST_RACK = 3'd6;

    // ----------------------------------------------------------------
    // decode functions
    // ----------------------------------------------------------------
    // weighted limit decode
    function [6:0] cl_pct;
        input [3:0] code;
        begin
            cl_pct = 7'd100;
            if (!code[0]) cl_pct = cl_pct - 7'd`HPC_CL_W0;
            if (!code[1]) cl_pct = cl_pct - 7'd`HPC_CL_W1;
            if (!code[2]) cl_pct = cl_pct - 7'd`HPC_CL_W2;
            if (!code[3]) cl_pct = cl_pct - 7'd`HPC_CL_W3;
        end
    endfunction

    function [9:0] cl_mv;
        input [6:0] pct;
        reg [16:0] prod;
        begin
            prod = (17'd`HPC_CL_MAX_MV * {10'd0, pct}) / 17'd100;
            // quotient never exceeds the full-scale 675, so ten bits hold it
            cl_mv = prod[9:0];
        end
    endfunction

    function [13:0] pg_mv;
        input [1:0] code;
        begin
            pg_mv = 14'd`HPC_PG_MAX_MV;
            if (!code[0]) pg_mv = pg_mv - 14'd`HPC_PG_B0_MV;
            if (!code[1]) pg_mv = pg_mv - 14'd`HPC_PG_B1_MV;
        end
    endfunction

    function [13:0] ft_us;
        input [4:0] code;
        begin
            ft_us = {9'd0, code} * 14'd`HPC_FT_LSB_US;
        end
    endfunction

    // turn-on waits for a discharged output when interlocked
    function on_next;
        input en;
        input uv;
        input low;
        input on;
        begin
            if (!en)
                on_next = 1'b0;
            else if (on)
                on_next = 1'b1;
            else
                on_next = !uv || low;
        end
    endfunction

    // ----------------------------------------------------------------
    // registers and bus state
    // ----------------------------------------------------------------
    reg [7:0] a_hi_limits_r;
    reg [7:0] a_hi_timing_r;
    reg [7:0] a_lo_timing_r;
    reg [7:0] b_hi_limits_r;
    reg [7:0] b_hi_timing_r;
    reg [2:0] state_r;
    reg [3:0] cnt_r;
    reg [7:0] shift_r;
    reg [7:0] tx_r;
    reg [7:0] ptr_r;
    reg ptr_ok_r;
    reg rw_r;
    reg mack_r;
    reg scl_r;
    reg sda_r;
    reg scl_p_r;
    reg sda_p_r;
    reg a_hi_on_r;
    reg a_lo_on_r;
    reg b_hi_on_r;
    reg [7:0] rd_data;

    wire scl_rise = scl_r && !scl_p_r;
    wire scl_fall = !scl_r && scl_p_r;
    wire start_c = scl_r && scl_p_r && sda_p_r && !sda_r;
    wire stop_c = scl_r && scl_p_r && !sda_p_r && sda_r;
    wire [7:0] ptr_inc = ptr_r + 8'd1;

    // open drain: only ever pulls low
    assign sda_out = 1'b0;

    // read mux returns stored values, unmapped reads zero
    always @* begin
        case (ptr_r)
            `HPC_OFS_A_HI_LIMITS: rd_data = a_hi_limits_r;
            `HPC_OFS_A_HI_TIMING: rd_data = a_hi_timing_r;
            `HPC_OFS_A_LO_TIMING: rd_data = a_lo_timing_r;
            `HPC_OFS_B_HI_LIMITS: rd_data = b_hi_limits_r;
            `HPC_OFS_B_HI_TIMING: rd_data = b_hi_timing_r;
            default: rd_data = 8'h00;
        endcase
    end

    // pin sampling for edge and start/stop detection
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            scl_p_r <= 1'b1;
            sda_p_r <= 1'b1;
        end else begin
            scl_r <= scl_in;
            sda_r <= sda_in;
            scl_p_r <= scl_r;
            sda_p_r <= sda_r;
        end
    end

    // i2c slave: pointer byte first, then data with auto-increment
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'd0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            ptr_r <= 8'h00;
            ptr_ok_r <= 1'b0;
            rw_r <= 1'b0;
            mack_r <= 1'b0;
            sda_oe <= 1'b0;
            a_hi_limits_r <= `HPC_RST_LIMITS;
            a_hi_timing_r <= `HPC_RST_TIMING;
            a_lo_timing_r <= `HPC_RST_TIMING;
            b_hi_limits_r <= `HPC_RST_LIMITS;
            b_hi_timing_r <= `HPC_RST_TIMING;
        end else if (start_c) begin
            // repeated start keeps the pointer for a following read
            state_r <= ST_DEV;
            cnt_r <= 4'd0;
            ptr_ok_r <= 1'b0;
            sda_oe <= 1'b0;
        end else if (stop_c) begin
            state_r <= ST_IDLE;
            sda_oe <= 1'b0;
        end else begin
            case (state_r)
                ST_DEV, ST_WR: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], sda_r};
                        cnt_r <= cnt_r + 4'd1;
                    end else if (scl_fall && cnt_r == 4'd8) begin
                        if (state_r == ST_DEV) begin
                            if (shift_r[7:1] == DEV_ADDR) begin
                                rw_r <= shift_r[0];
                                sda_oe <= 1'b1;
                                state_r <= ST_ACKD;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end else begin
                            if (!ptr_ok_r) begin
                                ptr_r <= shift_r;
                                ptr_ok_r <= 1'b1;
                            end else begin
                                // writes land in the addressed register
                                case (ptr_r)
                                    `HPC_OFS_A_HI_LIMITS: a_hi_limits_r <= shift_r;
                                    `HPC_OFS_A_HI_TIMING: a_hi_timing_r <= shift_r;
                                    `HPC_OFS_A_LO_TIMING: a_lo_timing_r <= shift_r;
                                    `HPC_OFS_B_HI_LIMITS: b_hi_limits_r <= shift_r;
                                    `HPC_OFS_B_HI_TIMING: b_hi_timing_r <= shift_r;
                                    default: ;
                                endcase
                                ptr_r <= ptr_inc;
                            end
                            sda_oe <= 1'b1;
                            state_r <= ST_ACKW;
                        end
                    end
                end
                ST_ACKD: begin
                    if (scl_fall) begin
                        cnt_r <= 4'd0;
                        if (rw_r) begin
                            tx_r <= rd_data;
                            sda_oe <= !rd_data[7];
                            state_r <= ST_RD;
                        end else begin
                            sda_oe <= 1'b0;
                            state_r <= ST_WR;
                        end
                    end
                end
                ST_ACKW: begin
                    if (scl_fall) begin
                        sda_oe <= 1'b0;
                        cnt_r <= 4'd0;
                        state_r <= ST_WR;
                    end
                end
                ST_RD: begin
                    if (scl_rise) begin
                        cnt_r <= cnt_r + 4'd1;
                    end else if (scl_fall) begin
                        if (cnt_r == 4'd8) begin
                            sda_oe <= 1'b0;
                            ptr_r <= ptr_inc;
                            state_r <= ST_RACK;
                        end else begin
                            tx_r <= {tx_r[6:0], 1'b0};
                            sda_oe <= !tx_r[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        mack_r <= !sda_r;
                    end else if (scl_fall) begin
                        // master nack ends the read burst
                        if (mack_r) begin
                            cnt_r <= 4'd0;
                            tx_r <= rd_data;
                            sda_oe <= !rd_data[7];
                            state_r <= ST_RD;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // channel on-state with restart interlock
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            a_hi_on_r <= 1'b0;
            a_lo_on_r <= 1'b0;
            b_hi_on_r <= 1'b0;
        end else begin
            // high rails run from the master enable
            // slot B timing register drives its channel
            a_hi_on_r <= on_next(a_hi_timing_r[`HPC_EN_BIT], a_hi_timing_r[`HPC_UV_BIT],
                                 a_hi_output_low, a_hi_on_r);
            b_hi_on_r <= on_next(b_hi_timing_r[`HPC_EN_BIT], b_hi_timing_r[`HPC_UV_BIT],
                                 b_hi_output_low, b_hi_on_r);
            // low rail needs bit and pin together
            a_lo_on_r <= on_next(a_lo_timing_r[`HPC_EN_BIT] && a_lo_enable_pin,
                                 a_lo_timing_r[`HPC_UV_BIT], a_lo_output_low, a_lo_on_r);
        end
    end

    // ----------------------------------------------------------------
    // gate drive and decoded settings
    // ----------------------------------------------------------------
    assign a_pass_gate_out = a_hi_on_r;
    assign b_pass_gate_out = b_hi_on_r;
    assign a_lo_gate_drive = a_lo_on_r;
    // cleared ORing enable keeps the blocking gate low
    assign a_blocking_gate_out = a_hi_on_r && a_hi_limits_r[`HPC_OR_BIT];
    assign b_blocking_gate_out = b_hi_on_r && b_hi_limits_r[`HPC_OR_BIT];

    assign a_hi_current_limit_code = a_hi_limits_r[`HPC_CL_LSB+3:`HPC_CL_LSB];
    assign b_hi_current_limit_code = b_hi_limits_r[`HPC_CL_LSB+3:`HPC_CL_LSB];
    // zero code lands at 25 percent
    assign a_hi_limit_pct = cl_pct(a_hi_current_limit_code);
    assign b_hi_limit_pct = cl_pct(b_hi_current_limit_code);
    assign a_hi_limit_mv = cl_mv(a_hi_limit_pct);
    assign b_hi_limit_mv = cl_mv(b_hi_limit_pct);
    // fast trip of 100 mV max equals the percentage in millivolts
    assign a_hi_fast_trip_mv = a_hi_limit_pct;
    assign b_hi_fast_trip_mv = b_hi_limit_pct;

    assign a_hi_power_good_code = a_hi_limits_r[`HPC_PG_LSB+1:`HPC_PG_LSB];
    assign b_hi_power_good_code = b_hi_limits_r[`HPC_PG_LSB+1:`HPC_PG_LSB];
    assign a_hi_power_good_mv = pg_mv(a_hi_power_good_code);
    assign b_hi_power_good_mv = pg_mv(b_hi_power_good_code);

    assign a_hi_positive_turnoff_sel = a_hi_limits_r[`HPC_HP_BIT];
    assign b_hi_positive_turnoff_sel = b_hi_limits_r[`HPC_HP_BIT];
    assign a_hi_turnoff_mv = a_hi_positive_turnoff_sel ? 4'sd`HPC_TURNOFF_MV : -4'sd`HPC_TURNOFF_MV;
    assign b_hi_turnoff_mv = b_hi_positive_turnoff_sel ? 4'sd`HPC_TURNOFF_MV : -4'sd`HPC_TURNOFF_MV;

    // fault time fields; short values are software's to pick
    assign a_hi_fault_time_code = a_hi_timing_r[`HPC_FT_LSB+4:`HPC_FT_LSB];
    assign a_lo_fault_time_code = a_lo_timing_r[`HPC_FT_LSB+4:`HPC_FT_LSB];
    assign b_hi_fault_time_code = b_hi_timing_r[`HPC_FT_LSB+4:`HPC_FT_LSB];
    assign a_hi_fault_time_us = ft_us(a_hi_fault_time_code);
    assign a_lo_fault_time_us = ft_us(a_lo_fault_time_code);
    assign b_hi_fault_time_us = ft_us(b_hi_fault_time_code);

    assign a_hi_bleed_connect = a_hi_timing_r[`HPC_DS_BIT];
    assign a_lo_bleed_connect = a_lo_timing_r[`HPC_DS_BIT];
    assign b_hi_bleed_connect = b_hi_timing_r[`HPC_DS_BIT];

endmodule

/* hdl/hpc_consts.vh */
// constants for the hot-plug channel configuration register bank
// How it works
// - each cleared limit bit removes 5, 10, 20 or 40 percent of limit and fast trip.
// - all-ones limit code gives 675 mV limit and 100 mV fast trip.
// - all-zero limit code scales limit and fast trip to one quarter.
// - power-good code 11 gives 10.5 V; cleared bits drop 600 mV and 1.2 V.
// - positive turn-off select moves the ORing threshold from -3 mV to +3 mV.
// - cleared ORing enable holds the blocking gate low.
// - five-bit fault time, half millisecond steps, resets to code 1.
// - high-rail master enable on bit 5; cleared pulls pass and blocking gates low.
// - all master enables reset to zero, every channel starts disabled.
// - interlock set blocks turn-on until the output is below 100 mV.
// - cleared bleed bit disconnects the output bleed resistor.
// - low rail runs only with enable bit and enable pin both asserted.
// - slot B high rail limits register decodes like slot A.
// - slot B high rail timing register decodes like slot A timing.
`ifndef HPC_CONSTS_VH
`define HPC_CONSTS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define HPC_OFS_A_HI_LIMITS 8'h00
`define HPC_OFS_A_HI_TIMING 8'h01
`define HPC_OFS_A_LO_TIMING 8'h02
`define HPC_OFS_B_HI_LIMITS 8'h03
`define HPC_OFS_B_HI_TIMING 8'h04

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define HPC_RST_LIMITS 8'hBF
`define HPC_RST_TIMING 8'h01
`define HPC_CL_LSB 0
`define HPC_PG_LSB 4
`define HPC_HP_BIT 6
`define HPC_OR_BIT 7
`define HPC_FT_LSB 0
`define HPC_EN_BIT 5
`define HPC_UV_BIT 6
`define HPC_DS_BIT 7

// ----------------------------------------------------------------
// analog figures
// ----------------------------------------------------------------
`define HPC_CL_MAX_MV 675
`define HPC_FT_MAX_MV 100
`define HPC_CL_W0 5
`define HPC_CL_W1 10
`define HPC_CL_W2 20
`define HPC_CL_W3 40
`define HPC_PG_MAX_MV 10500
`define HPC_PG_B0_MV 600
`define HPC_PG_B1_MV 1200
`define HPC_TURNOFF_MV 3
`define HPC_FT_LSB_US 500

`endif

/* tb/hpc_config_regs_chk.sv */
// checker on the decoded settings and gate drives of the register bank
module hpc_config_regs_chk (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic a_lo_enable_pin,
    input wire logic a_pass_gate_out,
    input wire logic a_blocking_gate_out,
    input wire logic a_lo_gate_drive,
    input wire logic [3:0] a_hi_current_limit_code,
    input wire logic [6:0] a_hi_limit_pct,
    input wire logic [9:0] a_hi_limit_mv,
    input wire logic [6:0] a_hi_fast_trip_mv,
    input wire logic [1:0] a_hi_power_good_code,
    input wire logic [13:0] a_hi_power_good_mv,
    input wire logic a_hi_positive_turnoff_sel,
    input wire logic signed [3:0] a_hi_turnoff_mv,
    input wire logic [4:0] a_hi_fault_time_code,
    input wire logic [13:0] a_hi_fault_time_us
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------
    // decode and gate relations
    // ---------------------------------------------
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // percent left once the weights of cleared limit bits are taken off
    function automatic int pct(logic [3:0] c);
        return 100 - (c[0] ? 0 : 5) - (c[1] ? 0 : 10) - (c[2] ? 0 : 20) - (c[3] ? 0 : 40);
    endfunction
    limit_pct_a: assert property (a_hi_limit_pct == pct(a_hi_current_limit_code))
        else $error("limit percent does not follow its code");
    limit_mv_a: assert property (
        a_hi_limit_mv == (675 * a_hi_limit_pct) / 100 && a_hi_fast_trip_mv == a_hi_limit_pct)
        else $error("limit or fast trip level wrong");
    quarter_scale_a: assert property (
        a_hi_current_limit_code == 4'h0 |-> a_hi_limit_mv == 10'hA8 ##0 a_hi_fast_trip_mv == 7'h19)
        else $error("all-clear code is not one quarter");
    good_level_a: assert property (
        a_hi_power_good_mv == 10500 - (a_hi_power_good_code[0] ? 0 : 600) - (a_hi_power_good_code[1] ? 0 : 1200))
        else $error("power-good level wrong");
    turnoff_sign_a: assert property (a_hi_turnoff_mv == (a_hi_positive_turnoff_sel ? 4'sh3 : -4'sh3))
        else $error("turn-off threshold wrong");
    block_needs_pass_a: assert property ($rose(a_blocking_gate_out) |-> a_pass_gate_out)
        else $error("blocking gate on without the pass gate");
    fault_span_a: assert property (a_hi_fault_time_us == a_hi_fault_time_code * 500)
        else $error("fault time wrong");
    reset_off_a: assert property ($rose(rst_n) |-> (!a_pass_gate_out && !a_lo_gate_drive)[*2])
        else $error("gate on straight after reset");
    pin_drop_a: assert property (!a_lo_enable_pin [*3] |-> !a_lo_gate_drive)
        else $error("low rail driven with its pin low");
endmodule

/* tb/hpc_i2c_host.sv */
// i2c host model on an open-drain data wire with a pull-up
module hpc_i2c_host (
    input wire logic ref_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------
    // bus cycles, every move on a falling edge
    // ---------------------------------------------
    localparam int PH = 5; // five clocks a phase, above the four recommended
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // one bit: data moves two clocks after scl falls so the device hold is kept
    task automatic bit_io(input logic b, output logic s);
        sda_pull = ~b;
        repeat (PH) @(negedge ref_clk);
        scl = 1'b1;
        repeat (PH) @(negedge ref_clk);
        s = sda;
        scl = 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask
    // start when go is set, stop otherwise: data moves while scl is high
    task automatic frame(input logic go);
        sda_pull = ~go;
        repeat (PH) @(negedge ref_clk);
        scl = 1'b1;
        repeat (PH) @(negedge ref_clk);
        sda_pull = go;
        repeat (PH) @(negedge ref_clk);
        scl = ~go;
        repeat (2) @(negedge ref_clk);
    endtask
    // byte out msb first, then the device acknowledge
    task automatic put(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    // byte in; the host acknowledges all but the last
    task automatic get(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, s);
    endtask
endmodule

/* tb/test_hpc_config_regs.sv */
// self-checking bench for the hot-plug configuration register bank
module test_hpc_config_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst_n, en_pin, a_low, l_low, b_low;
    logic a_on, l_on, b_on;
    logic [7:0] m [0:4];
    logic [31:0] rs = 32'h92E87414;
    int n_fail = 0, n_tests = 0, cyc = 0;
    wire scl, sda_pull, sda_out, sda_oe, sda, a_pass, a_blk, l_drv, b_pass, b_blk;
    wire a_hp, b_hp, a_bl, l_bl, b_bl;
    wire [3:0] a_cl, b_cl;
    wire signed [3:0] a_to, b_to;
    wire [1:0] a_pg, b_pg;
    wire [4:0] a_fc, l_fc, b_fc;
    wire [6:0] a_pct, b_pct, a_ft, b_ft;
    wire [9:0] a_lmv, b_lmv;
    wire [13:0] a_pgv, b_pgv, a_fu, l_fu, b_fu;
    // open-drain data wire: low when any party pulls, else the pull-up
    assign sda = (sda_pull | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;
    always #5 ref_clk = ~ref_clk;
    hpc_i2c_host host (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
    hpc_config_regs #(.DEV_ADDR(7'h40)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .a_lo_enable_pin(en_pin), .a_hi_output_low(a_low), .a_lo_output_low(l_low), .b_hi_output_low(b_low),
        .a_pass_gate_out(a_pass), .a_blocking_gate_out(a_blk), .a_lo_gate_drive(l_drv),
        .b_pass_gate_out(b_pass), .b_blocking_gate_out(b_blk), .a_hi_current_limit_code(a_cl),
        .b_hi_current_limit_code(b_cl), .a_hi_limit_pct(a_pct), .b_hi_limit_pct(b_pct), .a_hi_limit_mv(a_lmv),
        .b_hi_limit_mv(b_lmv), .a_hi_fast_trip_mv(a_ft), .b_hi_fast_trip_mv(b_ft), .a_hi_power_good_code(a_pg),
        .b_hi_power_good_code(b_pg), .a_hi_power_good_mv(a_pgv), .b_hi_power_good_mv(b_pgv),
        .a_hi_positive_turnoff_sel(a_hp), .b_hi_positive_turnoff_sel(b_hp), .a_hi_turnoff_mv(a_to),
        .b_hi_turnoff_mv(b_to), .a_hi_fault_time_code(a_fc), .a_lo_fault_time_code(l_fc),
        .b_hi_fault_time_code(b_fc), .a_hi_fault_time_us(a_fu), .a_lo_fault_time_us(l_fu),
        .b_hi_fault_time_us(b_fu), .a_hi_bleed_connect(a_bl), .a_lo_bleed_connect(l_bl), .b_hi_bleed_connect(b_bl)
    );
    // ---------------------------------------------
    // model, compare and bus tasks
    // ---------------------------------------------
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // high-rail limits register decode, worked out from the bit weights
    task automatic hi_chk(input logic [7:0] r, input logic [3:0] cl, input logic [6:0] pct, input logic [9:0] lmv,
            input logic [6:0] ft, input logic [1:0] pg, input logic [13:0] pgv, input logic hp, input logic [3:0] to);
        int p;
        p = 100 - (r[0] ? 0 : 5) - (r[1] ? 0 : 10) - (r[2] ? 0 : 20) - (r[3] ? 0 : 40);
        chk(cl, r[3:0]);
        chk(pct, p);
        chk(lmv, 675 * p / 100);
        chk(ft, p);
        chk(pg, r[5:4]);
        chk(pgv, 10500 - (r[4] ? 0 : 600) - (r[5] ? 0 : 1200));
        chk(hp, r[6]);
        chk(to, r[6] ? 4'h3 : 4'hD);
    endtask
    task automatic tm_chk(input logic [7:0] r, input logic [4:0] fc, input logic [13:0] fu, input logic bl);
        chk(fc, r[4:0]);
        chk(fu, r[4:0] * 500);
        chk(bl, r[7]);
    endtask
    // on state is sticky while enabled; the interlock only gates turn-on
    task automatic settle();
        repeat (6) @(negedge ref_clk);
        a_on = m[1][5] & (a_on | ~m[1][6] | a_low);
        l_on = m[2][5] & en_pin & (l_on | ~m[2][6] | l_low);
        b_on = m[4][5] & (b_on | ~m[4][6] | b_low);
        chk(a_pass, a_on);
        chk(a_blk, a_on & m[0][7]);
        chk(l_drv, l_on);
        chk(b_pass, b_on);
        chk(b_blk, b_on & m[3][7]);
        hi_chk(m[0], a_cl, a_pct, a_lmv, a_ft, a_pg, a_pgv, a_hp, a_to);
        hi_chk(m[3], b_cl, b_pct, b_lmv, b_ft, b_pg, b_pgv, b_hp, b_to);
        tm_chk(m[1], a_fc, a_fu, a_bl);
        tm_chk(m[2], l_fc, l_fu, l_bl);
        tm_chk(m[4], b_fc, b_fu, b_bl);
    endtask
    // write burst from pointer p; pointer steps one per byte
    task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
        logic k0, k1;
        host.frame(1'b1);
        host.put(8'h80, k0);
        host.put(p, k1);
        chk(k0 & k1, 1'b1);
        foreach (d[i]) begin
            host.put(d[i], k1);
            chk(k1, 1'b1);
            if (p + i < 5) m[p + i] = d[i];
        end
        host.frame(1'b0);
        settle();
    endtask
    // read n bytes from pointer p through a repeated start
    task automatic rd(input logic [7:0] p, input int n);
        logic k0, k1, k2;
        logic [7:0] v;
        host.frame(1'b1);
        host.put(8'h80, k0);
        host.put(p, k1);
        host.frame(1'b1);
        host.put(8'h81, k2);
        chk(k0 & k1 & k2, 1'b1);
        for (int i = 0; i < n; i++) begin
            host.get(i == n - 1, v);
            chk(v, (p + i < 5) ? m[p + i] : 8'h00);
        end
        host.frame(1'b0);
    endtask
    task automatic rst_seq();
        rst_n = 1'b0;
        m = '{8'hBF, 8'h01, 8'h01, 8'hBF, 8'h01};
        {a_on, l_on, b_on} = 3'h0;
        repeat (6) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        settle();
        rd(8'h00, 5);
    endtask
    // cut a hang short; the full run is near 36500 cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 80000) begin
            n_fail++;
            conclude();
        end
    end
    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        logic k;
        logic [7:0] p;
        {en_pin, a_low, l_low, b_low} = 4'h0;
        rst_seq();
        // every limit code on both slots, power-good and turn-off codes riding along
        for (int i = 0; i < 16; i++) begin
            p = {i[0], i[1], i[1:0], i[3:0]};
            wr(8'h00, '{p, 8'h01, 8'h01, ~p});
        end
        rd(8'h00, 4);
        // interlock holds turn-on until the output has bled down
        wr(8'h01, '{8'h61});
        a_low = 1'b1;
        settle();
        a_low = 1'b0;
        settle();
        wr(8'h00, '{8'h3F});
        wr(8'h01, '{8'h41});
        // low rail needs both the enable bit and the pin
        wr(8'h02, '{8'h20});
        en_pin = 1'b1;
        settle();
        wr(8'h02, '{8'h80});
        // redundant feeds: bleed cleared, fault time cut back once charged
        wr(8'h04, '{8'h3F});
        wr(8'h04, '{8'h23});
        wr(8'h07, '{8'h5A});
        rd(8'h07, 1);
        // a foreign address is left unanswered
        host.frame(1'b1);
        host.put(8'hA2, k);
        host.frame(1'b0);
        chk(k, 1'b0);
        for (int i = 0; i < 20; i++) begin
            p = 8'(rnd());
            en_pin = p[0];
            a_low = p[1];
            l_low = p[2];
            b_low = p[3];
            settle();
            p = 8'(rnd() % 5);
            wr(p, '{8'(rnd())});
            rd(p, 2);
        end
        rst_seq();
        conclude();
    end
endmodule
bind hpc_config_regs hpc_config_regs_chk chk (.ref_clk(ref_clk), .rst_n(rst_n), .a_lo_enable_pin(a_lo_enable_pin),
    .a_pass_gate_out(a_pass_gate_out), .a_blocking_gate_out(a_blocking_gate_out), .a_lo_gate_drive(a_lo_gate_drive),
    .a_hi_current_limit_code(a_hi_current_limit_code), .a_hi_limit_pct(a_hi_limit_pct), .a_hi_limit_mv(a_hi_limit_mv),
    .a_hi_fast_trip_mv(a_hi_fast_trip_mv), .a_hi_power_good_code(a_hi_power_good_code),
    .a_hi_power_good_mv(a_hi_power_good_mv), .a_hi_positive_turnoff_sel(a_hi_positive_turnoff_sel),
    .a_hi_turnoff_mv(a_hi_turnoff_mv), .a_hi_fault_time_code(a_hi_fault_time_code),
    .a_hi_fault_time_us(a_hi_fault_time_us));
